/* File: design/iop_top.sv */
// io port command handler with apb register access
`timescale 1ns/100ps
`default_nettype none
module iop_top
    import iop_pkg::*;
#(
    parameter int ADC_W = 12
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [7:0] din,
    input wire logic [ADC_W-1:0] adc0,
    input wire logic [ADC_W-1:0] adc4,
    input wire logic [15:0] supply,
    input wire logic [15:0] tmp0,
    input wire logic [15:0] tmp1,
    input wire logic [15:0] tmp2,
    output logic [7:0] dout,
    output logic [1:0] pullup_en,
    output logic busy
);
    ////////////////////////////////////////////////////////////////////////
    // registers
    logic [31:0] cmd_q;
    logic [31:0] val_q;
    logic prog_q;
    logic [31:0] acc_q;
    logic [31:0] acc_d;
    logic [7:0] out_q;
    logic [7:0] out_d;
    logic [1:0] pull_q;
    logic [1:0] pull_d;
    logic [7:0] st_q;
    logic [7:0] st_d;
    logic [31:0] rval_q;
    logic [31:0] rval_d;
    logic [31:0] prdata_q;
    logic pready_q;
    logic pslverr_q;
    logic done_q;
    logic busy_q;
    iop_state_e state_q;
    iop_state_e state_d;

    ////////////////////////////////////////////////////////////////////////
    // apb decode
    wire acc_phase = psel & penable;
    wire wr_en = acc_phase & pwrite & ~pready_q;
    wire rd_en = acc_phase & ~pwrite & ~pready_q;
    wire hit_cmd = (paddr == IOP_CMD_OFS);
    wire hit_val = (paddr == IOP_VAL_OFS);
    wire hit_ctl = (paddr == IOP_CTL_OFS);
    wire hit_stat = (paddr == IOP_STAT_OFS);
    wire hit_rval = (paddr == IOP_RVAL_OFS);
    wire hit_acc = (paddr == IOP_ACC_OFS);
    wire hit_out = (paddr == IOP_OUT_OFS);
    wire hit_pull = (paddr == IOP_PULL_OFS);
    wire hit_adc0 = (paddr == IOP_ADC0_OFS);
    wire hit_adc4 = (paddr == IOP_ADC4_OFS);
    wire hit_sup = (paddr == IOP_SUP_OFS);
    wire hit_t0 = (paddr == IOP_TMP0_OFS);
    wire hit_t1 = (paddr == IOP_TMP1_OFS);
    wire hit_t2 = (paddr == IOP_TMP2_OFS);
    wire hit_any = hit_cmd | hit_val | hit_ctl | hit_stat | hit_rval | hit_acc | hit_out | hit_pull
        | hit_adc0 | hit_adc4 | hit_sup | hit_t0 | hit_t1 | hit_t2;
    wire busy_w = (state_q != IOP_IDLE);
    // writing cmd/val while a command runs would corrupt it, so refuse them
    wire wr_blocked = busy_w & (hit_cmd | hit_val | hit_ctl);
    wire bad_acc = ~hit_any | (pwrite & wr_blocked);
    wire go = wr_en & hit_ctl & ~busy_w & pwdata[IOP_CTL_GO_BIT];

    ////////////////////////////////////////////////////////////////////////
    // frame fields, address byte is cmd_q[31:24]
    wire [7:0] f_instr = cmd_q[23:16];
    wire [7:0] f_type = cmd_q[15:8];
    wire [7:0] f_bank = cmd_q[7:0];
    wire [7:0] csum_calc;
    wire [31:0] sel_val;
    wire sel_ok;

    iop_csum u_csum
    (
        .cmd_word(cmd_q),
        .val_word(val_q),
        .sum(csum_calc)
    );

    iop_sel #(.ADC_W(ADC_W)) u_sel
    (
        .port_num(f_type),
        .bank_num(f_bank),
        .din(din),
        .dout(out_q),
        .adc0(adc0),
        .adc4(adc4),
        .supply(supply),
        .tmp0(tmp0),
        .tmp1(tmp1),
        .tmp2(tmp2),
        .value(sel_val),
        .valid(sel_ok)
    );

    // checksum byte is held in ctl write data bits 15:8, latched with the go bit
    logic [7:0] csum_q;
    wire csum_ok = (csum_q == csum_calc);

    ////////////////////////////////////////////////////////////////////////
    // set output decode
    wire is_set = (f_instr == IOP_INSTR_SET);
    wire is_get = (f_instr == IOP_INSTR_GET);
    wire set_one = (f_bank == IOP_BANK_OUT) & (f_type < 8'h08);
    wire set_all = (f_bank == IOP_BANK_OUT) & (f_type == IOP_PORT_ALL);
    wire set_pull = (f_bank == IOP_BANK_IN) & (f_type == 8'h00);
    wire val_bit_ok = (val_q[31:1] == 31'h00000000);
    wire val_all_acc = (val_q == IOP_VAL_FROM_ACC);
    wire val_byte_ok = (val_q[31:8] == 24'h000000);
    wire [7:0] one_hot = 8'h01 << f_type[2:0];
    wire [7:0] set_one_vec = val_q[0] ? (out_q | one_hot) : (out_q & ~one_hot);
    wire [7:0] set_all_vec = val_all_acc ? acc_q[7:0] : val_q[7:0];

    ////////////////////////////////////////////////////////////////////////
    // command execution, one cycle in the exec phase
    always_comb
    begin
        state_d = state_q;
        acc_d = acc_q;
        out_d = out_q;
        pull_d = pull_q;
        st_d = st_q;
        rval_d = rval_q;
        case (state_q)
            IOP_IDLE:
            begin
                if (go)
                    state_d = IOP_EXEC;
            end
            IOP_EXEC:
            begin
                state_d = IOP_DONE;
                rval_d = 32'h00000000;
                st_d = IOP_ST_OK;
                if (!csum_ok)
                    st_d = IOP_ST_BAD_CSUM;
                else if (is_set)
                begin
                    if (set_one && val_bit_ok)
                        out_d = set_one_vec;
                    else if (set_all && (val_byte_ok || val_all_acc))
                        out_d = set_all_vec;
                    else if (set_pull)
                        pull_d = val_q[1:0];
                    else if (set_one || set_all)
                        st_d = IOP_ST_BAD_VAL;
                    else
                        st_d = IOP_ST_BAD_TYPE;
                end
                else if (is_get)
                begin
                    if (sel_ok)
                    begin
                        rval_d = sel_val;
                        if (prog_q)
                            acc_d = sel_val;
                        else if (f_type == IOP_PORT_ALL)
                            acc_d = {acc_q[31:8], sel_val[7:0]};
                    end
                    else
                        st_d = IOP_ST_BAD_TYPE;
                end
                else
                    st_d = IOP_ST_BAD_CMD;
            end
            IOP_DONE:
            begin
                state_d = IOP_IDLE;
            end
            default:
            begin
                state_d = IOP_IDLE;
            end
        endcase
    end
    // direct mode leaves the accumulator alone except the all-inputs capture

    ////////////////////////////////////////////////////////////////////////
    // read mux
    wire [31:0] rd_mux =
        hit_cmd ? cmd_q :
        hit_val ? val_q :
        hit_ctl ? {16'h0000, csum_q, 6'h00, prog_q, busy_w} :
        hit_stat ? {23'h000000, done_q, st_q} :
        hit_rval ? rval_q :
        hit_acc ? acc_q :
        hit_out ? {24'h000000, out_q} :
        hit_pull ? {30'h00000000, pull_q} :
        hit_adc0 ? {{(32-ADC_W){1'b0}}, adc0} :
        hit_adc4 ? {{(32-ADC_W){1'b0}}, adc4} :
        hit_sup ? {16'h0000, supply} :
        hit_t0 ? {16'h0000, tmp0} :
        hit_t1 ? {16'h0000, tmp1} :
        hit_t2 ? {16'h0000, tmp2} : 32'h00000000;

    ////////////////////////////////////////////////////////////////////////
    // apb answer, one wait state, pready pulses for one cycle
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h00000000;
        end
        else
        begin
            pready_q <= acc_phase & ~pready_q;
            pslverr_q <= acc_phase & ~pready_q & bad_acc;
            prdata_q <= rd_en ? rd_mux : 32'h00000000;
        end
    end

    // software-written frame registers
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cmd_q <= 32'h00000000;
            val_q <= 32'h00000000;
            prog_q <= 1'b0;
            csum_q <= 8'h00;
        end
        else if (wr_en && !wr_blocked)
        begin
            if (hit_cmd)
                cmd_q <= pwdata;
            if (hit_val)
                val_q <= pwdata;
            if (hit_ctl)
            begin
                prog_q <= pwdata[IOP_CTL_PROG_BIT];
                csum_q <= pwdata[15:8];
            end
        end
    end

    // done flag: set by completion wins over a clear by a status write
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            done_q <= 1'b0;
        else if (state_q == IOP_EXEC)
            done_q <= 1'b1;
        else if (wr_en && hit_stat && pwdata[8])
            done_q <= 1'b0;
    end

    // execution state and results; accumulator also writable by software
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_q <= IOP_IDLE;
            out_q <= IOP_OUT_RST;
            pull_q <= IOP_PULL_RST;
            st_q <= 8'h00;
            rval_q <= 32'h00000000;
            acc_q <= 32'h00000000;
            busy_q <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            out_q <= out_d;
            pull_q <= pull_d;
            st_q <= st_d;
            rval_q <= rval_d;
            acc_q <= (wr_en && hit_acc && !busy_w) ? pwdata : acc_d;
            busy_q <= (state_d != IOP_IDLE);
        end
    end

    // outputs straight from flip-flops
    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign dout = out_q;
    assign pullup_en = pull_q;
    assign busy = busy_q; // registered copy of the state decode
endmodule
`default_nettype wire

/* File: design/iop_pkg.sv */
// constants and types shared by the io port command handler
// Notes on behaviour
// - set output on bank 2, port 0..7 drives that line to value bit 0
// - set output port 255 bank 2 writes all eight lines from value bits 7..0
// - all-outputs set with value -1 takes the bit vector from the accumulator
// - set output port 0 bank 0: bit 0 pull-ups motors 0..2, bit 1 motors 3..5
// - after reset both pull-up groups are on, control value 3
// - get input selects line by type as port and motor/bank as bank; value ignored
// - digital lines read 0 or 1, adc channels 12-bit unsigned 0..4095
// - get input from a stored program writes the read value into the accumulator
// - get input from the host replies with the value, accumulator unchanged except for port 255 bank 0
// - successful get input answers status 100 with the port state as value
// - bank 0 ports 0..7 give the eight digital input levels
// - get input port 255 bank 0 puts all eight inputs in accumulator low bits
// - bank 1: adc at ports 0 and 4, supply at 8, temperatures at 9..11
// - bank 2 get input returns the output levels last set
package iop_pkg;
    // apb register byte offsets
    localparam logic [7:0] IOP_CMD_OFS = 8'h00;
    localparam logic [7:0] IOP_VAL_OFS = 8'h04;
    localparam logic [7:0] IOP_CTL_OFS = 8'h08;
    localparam logic [7:0] IOP_STAT_OFS = 8'h0c;
    localparam logic [7:0] IOP_RVAL_OFS = 8'h10;
    localparam logic [7:0] IOP_ACC_OFS = 8'h14;
    localparam logic [7:0] IOP_OUT_OFS = 8'h18;
    localparam logic [7:0] IOP_PULL_OFS = 8'h1c;
    localparam logic [7:0] IOP_ADC0_OFS = 8'h20;
    localparam logic [7:0] IOP_ADC4_OFS = 8'h24;
    localparam logic [7:0] IOP_SUP_OFS = 8'h28;
    localparam logic [7:0] IOP_TMP0_OFS = 8'h2c;
    localparam logic [7:0] IOP_TMP1_OFS = 8'h30;
    localparam logic [7:0] IOP_TMP2_OFS = 8'h34;
    // instruction codes
    localparam logic [7:0] IOP_INSTR_SET = 8'h0e;
    localparam logic [7:0] IOP_INSTR_GET = 8'h0f;
    // bank numbers and special ports
    localparam logic [7:0] IOP_BANK_IN = 8'h00;
    localparam logic [7:0] IOP_BANK_ADC = 8'h01;
    localparam logic [7:0] IOP_BANK_OUT = 8'h02;
    localparam logic [7:0] IOP_PORT_ALL = 8'hff;
    localparam logic [7:0] IOP_PORT_ADC0 = 8'h00;
    localparam logic [7:0] IOP_PORT_ADC4 = 8'h04;
    localparam logic [7:0] IOP_PORT_SUP = 8'h08;
    localparam logic [7:0] IOP_PORT_TMP0 = 8'h09;
    localparam logic [7:0] IOP_PORT_TMP1 = 8'h0a;
    localparam logic [7:0] IOP_PORT_TMP2 = 8'h0b;
    localparam logic [31:0] IOP_VAL_FROM_ACC = 32'hffffffff;
    // status codes
    localparam logic [7:0] IOP_ST_OK = 8'h64;
    localparam logic [7:0] IOP_ST_BAD_CSUM = 8'h01;
    localparam logic [7:0] IOP_ST_BAD_CMD = 8'h02;
    localparam logic [7:0] IOP_ST_BAD_TYPE = 8'h03;
    localparam logic [7:0] IOP_ST_BAD_VAL = 8'h04;
    // reset values
    localparam logic [1:0] IOP_PULL_RST = 2'h3;
    localparam logic [7:0] IOP_OUT_RST = 8'h00;
    // ctl register fields
    localparam int IOP_CTL_GO_BIT = 0;
    localparam int IOP_CTL_PROG_BIT = 1;
    // execution phases
    typedef enum logic [1:0] {IOP_IDLE, IOP_EXEC, IOP_DONE} iop_state_e;
endpackage

/* File: design/iop_csum.sv */
// modulo-256 checksum of one command frame
`timescale 1ns/100ps
`default_nettype none
module iop_csum
    import iop_pkg::*;
(
    input wire logic [31:0] cmd_word,
    input wire logic [31:0] val_word,
    output logic [7:0] sum
);
    // sum of address, instruction, type, bank and four value bytes
    assign sum = cmd_word[31:24] + cmd_word[23:16] + cmd_word[15:8] + cmd_word[7:0]
        + val_word[31:24] + val_word[23:16] + val_word[15:8] + val_word[7:0];
endmodule
`default_nettype wire

/* File: design/iop_sel.sv */
// port selection for the get input command
`timescale 1ns/100ps
`default_nettype none
module iop_sel
    import iop_pkg::*;
#(
    parameter int ADC_W = 12
)
(
    input wire logic [7:0] port_num,
    input wire logic [7:0] bank_num,
    input wire logic [7:0] din,
    input wire logic [7:0] dout,
    input wire logic [ADC_W-1:0] adc0,
    input wire logic [ADC_W-1:0] adc4,
    input wire logic [15:0] supply,
    input wire logic [15:0] tmp0,
    input wire logic [15:0] tmp1,
    input wire logic [15:0] tmp2,
    output logic [31:0] value,
    output logic valid
);
    // single digital bit lookups, ports above 7 give no bit
    wire port_lo = (port_num < 8'h08);
    wire [2:0] bit_idx = port_num[2:0];
    wire in_bit = din[bit_idx];
    wire out_bit = dout[bit_idx];
    wire is_all = (port_num == IOP_PORT_ALL);
    // single-line digital reads are 0/1, adc is unsigned and zero extended
    always_comb
    begin
        value = 32'h00000000;
        valid = 1'b0;
        if (bank_num == IOP_BANK_IN)
        begin
            if (is_all)
            begin
                value = {24'h000000, din};
                valid = 1'b1;
            end
            else if (port_lo)
            begin
                value = {31'h00000000, in_bit};
                valid = 1'b1;
            end
        end
        else if (bank_num == IOP_BANK_ADC)
        begin
            valid = 1'b1;
            if (port_num == IOP_PORT_ADC0)
                value = {{(32-ADC_W){1'b0}}, adc0};
            else if (port_num == IOP_PORT_ADC4)
                value = {{(32-ADC_W){1'b0}}, adc4};
            else if (port_num == IOP_PORT_SUP)
                value = {16'h0000, supply};
            else if (port_num == IOP_PORT_TMP0)
                value = {{16{tmp0[15]}}, tmp0};
            else if (port_num == IOP_PORT_TMP1)
                value = {{16{tmp1[15]}}, tmp1};
            else if (port_num == IOP_PORT_TMP2)
                value = {{16{tmp2[15]}}, tmp2};
            else
                valid = 1'b0;
        end
        else if (bank_num == IOP_BANK_OUT)
        begin
            if (port_lo)
            begin
                value = {31'h00000000, out_bit};
                valid = 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

/* File: verification/iop_top_asserts.sv */
// port checker for the io port command handler
`timescale 1ns/100ps
`default_nettype none
module iop_top_asserts
    import iop_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [7:0] dout,
    input wire logic [1:0] pullup_en,
    input wire logic busy
);
    ////////////////////////////////////////////////////////////////
    // single domain, reset masks every check
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    property p_pull_rst;
        $rose(presetn) |-> pullup_en == IOP_PULL_RST;
    endproperty
    a_pull_rst: assert property (p_pull_rst) else $error("pull-ups not on after reset");
    // outputs move only at the end of a running command
    property p_dout_cmd;
        !$stable(dout) |-> $past(busy);
    endproperty
    a_dout_cmd: assert property (p_dout_cmd) else $error("outputs moved outside a command");
    property p_pull_cmd;
        !$stable(pullup_en) |-> $past(busy);
    endproperty
    a_pull_cmd: assert property (p_pull_cmd) else $error("pull-ups moved outside a command");
    property p_busy_len;
        $rose(busy) |-> ##[1:3] !busy;
    endproperty
    a_busy_len: assert property (p_busy_len) else $error("command never completes");
    // a command starts only from a completed control write
    property p_busy_start;
        $rose(busy) |-> psel && penable && pwrite && pready && paddr == IOP_CTL_OFS;
    endproperty
    a_busy_start: assert property (p_busy_start) else $error("command without control write");
    property p_ready_wait;
        psel && penable && !pready |=> pready;
    endproperty
    a_ready_wait: assert property (p_ready_wait) else $error("access not answered in time");
    property p_err_ready;
        pslverr |-> pready && psel && penable;
    endproperty
    a_err_ready: assert property (p_err_ready) else $error("error outside an answer");
    property p_rdata_idle;
        !pready |-> prdata == 32'h0;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside an answer");
endmodule
`default_nettype wire

/* File: verification/iop_host.sv */
// apb host model sending command frames to the io port handler
`timescale 1ns/100ps
`default_nettype none
module iop_host
    import iop_pkg::*;
(
    input wire logic pclk,
    output var logic psel,
    output var logic penable,
    output var logic pwrite,
    output var logic [7:0] paddr,
    output var logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    ////////////////////////////////////////////////////////////////
    // bus idle at time zero
    initial
    begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
    end
    // one transfer from just after an edge; ends with an idle cycle so calls chain safely
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r,
                       output logic e);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // wait for the answer; a hang is cut by the bench timeout
        do
            @(posedge pclk);
        while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    // whole frame: clear done, command word, value word, go with frame sum; skew breaks the sum
    task automatic run_cmd(input logic [7:0] ins, input logic [7:0] port, input logic [7:0] bank,
                           input logic [31:0] val, input logic prog, input logic [7:0] skew,
                           output logic [31:0] st);
        logic [31:0] r;
        logic e;
        logic [7:0] cs;
        cs = 8'h01 + ins + port + bank + val[31:24] + val[23:16] + val[15:8] + val[7:0] + skew;
        apb(1'b1, IOP_STAT_OFS, 32'h100, r, e);
        apb(1'b1, IOP_CMD_OFS, {8'h01, ins, port, bank}, r, e);
        apb(1'b1, IOP_VAL_OFS, val, r, e);
        apb(1'b1, IOP_CTL_OFS, {16'h0, cs, 6'h0, prog, 1'b1}, r, e);
        st = 32'h0;
        // poll done; a hang is cut by the bench timeout
        while (st[8] !== 1'b1)
            apb(1'b0, IOP_STAT_OFS, 32'h0, st, e);
    endtask
endmodule
`default_nettype wire

/* File: verification/testbench.sv */
// self-checking testbench for the io port command handler
`timescale 1ns/100ps
`default_nettype none
module testbench
    import iop_pkg::*;
;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, busy;
    logic [7:0] paddr, din, dout;
    logic [31:0] pwdata, prdata;
    logic [11:0] adc0, adc4;
    logic [15:0] supply, tmp0, tmp1, tmp2;
    logic [1:0] pullup_en;
    int errors = 0;
    int comparisons = 0;
    int cycles = 0;
    ////////////////////////////////////////////////////////////////
    iop_top i_iop_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .din(din),
        .adc0(adc0), .adc4(adc4), .supply(supply), .tmp0(tmp0), .tmp1(tmp1), .tmp2(tmp2), .dout(dout),
        .pullup_en(pullup_en), .busy(busy));
    iop_host i_iop_host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
    ////////////////////////////////////////////////////////////////
    // 10 MHz clock
    initial
    begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end
    // hang guard, generous against about 900 expected cycles
    always @(posedge pclk)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            errors++;
            tally_and_finish;
        end
    end
    task automatic tally_and_finish;
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            errors++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] r);
        logic e;
        i_iop_host.apb(1'b0, a, 32'h0, r, e);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        i_iop_host.apb(1'b1, a, d, r, e);
    endtask
    task automatic cmd(input logic [7:0] ins, input logic [7:0] port, input logic [7:0] bank,
                       input logic [31:0] val, input logic prog);
        logic [31:0] st;
        i_iop_host.run_cmd(ins, port, bank, val, prog, 8'h00, st);
        check("status", st, {23'h0, 1'b1, IOP_ST_OK});
    endtask
    ////////////////////////////////////////////////////////////////
    // singles set lines one by one, then clear one and read back
    task automatic t_single;
        logic [31:0] r;
        logic [7:0] exp;
        exp = 8'h00;
        rd(IOP_PULL_OFS, r);
        check("pull reset", r, 32'h3);
        for (int p = 0; p < 8; p++)
        begin
            cmd(IOP_INSTR_SET, 8'(p), IOP_BANK_OUT, 32'h1, 1'b0);
            exp[p] = 1'b1;
            check("dout", {24'h0, dout}, {24'h0, exp});
        end
        cmd(IOP_INSTR_SET, 8'h03, IOP_BANK_OUT, 32'h0, 1'b0);
        check("dout", {24'h0, dout}, 32'hf7);
        cmd(IOP_INSTR_GET, 8'h03, IOP_BANK_OUT, 32'h0, 1'b0);
        rd(IOP_RVAL_OFS, r);
        check("readback 3", r, 32'h0);
        cmd(IOP_INSTR_GET, 8'h02, IOP_BANK_OUT, 32'h0, 1'b0);
        rd(IOP_RVAL_OFS, r);
        check("readback 2", r, 32'h1);
    endtask
    // all-lines set from value and from accumulator, then both pull-up bits
    task automatic t_all;
        cmd(IOP_INSTR_SET, IOP_PORT_ALL, IOP_BANK_OUT, 32'ha5, 1'b0);
        check("dout", {24'h0, dout}, 32'ha5);
        cmd(IOP_INSTR_SET, IOP_PORT_ALL, IOP_BANK_OUT, 32'hff, 1'b0);
        check("dout", {24'h0, dout}, 32'hff);
        wr(IOP_ACC_OFS, 32'h5a);
        cmd(IOP_INSTR_SET, IOP_PORT_ALL, IOP_BANK_OUT, IOP_VAL_FROM_ACC, 1'b0);
        check("dout", {24'h0, dout}, 32'h5a);
        for (int v = 0; v < 4; v++)
        begin
            cmd(IOP_INSTR_SET, 8'h00, IOP_BANK_IN, 32'(v), 1'b0);
            check("pull", {30'h0, pullup_en}, 32'(v));
        end
    endtask
    // direct single reads leave the accumulator; direct read of all loads its low byte
    task automatic t_inputs;
        logic [31:0] r;
        din <= 8'h96;
        wr(IOP_ACC_OFS, 32'h1234);
        for (int p = 0; p < 8; p++)
        begin
            cmd(IOP_INSTR_GET, 8'(p), IOP_BANK_IN, 32'h77, 1'b0);
            rd(IOP_RVAL_OFS, r);
            check("din bit", r, 32'(8'h96 >> p) & 32'h1);
        end
        rd(IOP_ACC_OFS, r);
        check("acc kept", r, 32'h1234);
        cmd(IOP_INSTR_GET, IOP_PORT_ALL, IOP_BANK_IN, 32'h0, 1'b0);
        rd(IOP_ACC_OFS, r);
        check("acc all", r, 32'h1296);
        cmd(IOP_INSTR_SET, IOP_PORT_ALL, IOP_BANK_OUT, IOP_VAL_FROM_ACC, 1'b0);
        check("copy", {24'h0, dout}, 32'h96);
    endtask
    // analog bank in program mode, full-scale and negative values
    task automatic t_analog;
        logic [31:0] r;
        logic [7:0] pt [6] = '{8'h00, 8'h04, 8'h08, 8'h09, 8'h0a, 8'h0b};
        logic [31:0] ex [6] = '{32'hfff, 32'h12e, 32'hf0, 32'hfffffff6, 32'h19, 32'h28};
        adc0 <= 12'hfff;
        adc4 <= 12'h12e;
        supply <= 16'h00f0;
        tmp0 <= 16'hfff6;
        tmp1 <= 16'h0019;
        tmp2 <= 16'h0028;
        for (int i = 0; i < 6; i++)
        begin
            cmd(IOP_INSTR_GET, pt[i], IOP_BANK_ADC, 32'h0, 1'b1);
            rd(IOP_RVAL_OFS, r);
            check("analog", r, ex[i]);
            rd(IOP_ACC_OFS, r);
            check("acc analog", r, ex[i]);
        end
    endtask
    // bad sum, unknown instruction, bad value and bad port are refused; unmapped read too
    task automatic t_bad;
        logic [31:0] r;
        logic e;
        i_iop_host.run_cmd(IOP_INSTR_SET, IOP_PORT_ALL, IOP_BANK_OUT, 32'h0, 1'b0, 8'h01, r);
        check("bad sum", {24'h0, r[7:0]}, {24'h0, IOP_ST_BAD_CSUM});
        check("dout kept", {24'h0, dout}, 32'h96);
        i_iop_host.run_cmd(8'h13, 8'h00, IOP_BANK_IN, 32'h0, 1'b0, 8'h00, r);
        check("bad instr", r, {23'h0, 1'b1, IOP_ST_BAD_CMD});
        i_iop_host.run_cmd(IOP_INSTR_SET, 8'h01, IOP_BANK_OUT, 32'h2, 1'b0, 8'h00, r);
        check("bad value", r, {23'h0, 1'b1, IOP_ST_BAD_VAL});
        check("dout same", {24'h0, dout}, 32'h96);
        i_iop_host.run_cmd(IOP_INSTR_GET, 8'h05, IOP_BANK_ADC, 32'h0, 1'b0, 8'h00, r);
        check("bad port", r, {23'h0, 1'b1, IOP_ST_BAD_TYPE});
        i_iop_host.apb(1'b0, 8'h3c, 32'h0, r, e);
        check("unmapped", {r[30:0], e}, 32'h1);
    endtask
    ////////////////////////////////////////////////////////////////
    // reset for three cycles, then the scenarios
    initial
    begin
        presetn = 1'b0;
        din = 8'h00;
        adc0 = 12'h000;
        adc4 = 12'h000;
        supply = 16'h0000;
        tmp0 = 16'h0000;
        tmp1 = 16'h0000;
        tmp2 = 16'h0000;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_single;
        t_all;
        t_inputs;
        t_analog;
        t_bad;
        tally_and_finish;
    end
endmodule
bind iop_top iop_top_asserts i_iop_top_asserts (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .dout(dout), .pullup_en(pullup_en), .busy(busy));
`default_nettype wire
